// File: crs_regset.sv
// Purpose: Programmer-visible register set of an 8-bit core.
// Assumes: Sequencer on the same clock; memory read data valid in the cycle of mem_re_o.
// Notes: An operation is taken when op_valid_i is high and busy_o is low.
// Notes on behaviour
// RULE1: Stack address low byte is the current stack pointer value.
// RULE2: Stack address high byte is 00 or 01 by the page select bit.
// RULE3: Indexed effective address is operand plus the first index register.
// RULE4: Second-index effective address is operand plus the second index register.
// RULE5: Program counter is 16 bits with separately loadable high and low halves.
// RULE6: An 8-bit accumulator carries the main data operations and transfers.
// RULE7: The stack pointer locates where registers are saved on calls and interrupts.
// RULE8: Accumulator and status each have their own push and pop operation.
// RULE9: Fast-set and shift-left-word operations are refused as illegal.
// RULE10: Stop, wait, multiply and divide operations are supported.
// RULE11: Page select and clock select bits live in the processor mode register.
// RULE12: Status bits from 0: carry, zero, irq off, decimal, break, index, overflow, negative.
// RULE13: Push writes then decrements the pointer; pop increments then reads.
`timescale 1ns/10ps
`include "crs_defs.svh"
module crs_regset
   import crs_pkg::*;
#(
   parameter int PC_W = 16
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input crs_op_t op_i,
   input wire logic [15:0] operand_i,
   input wire logic [7:0] data_i,
   input wire logic wake_i,
   output logic busy_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic mem_we_o,
   output logic mem_re_o,
   output logic [15:0] ea_o,
   output logic ea_valid_o,
   output logic illegal_o,
   output logic [7:0] acc_o,
   output logic [7:0] x_o,
   output logic [7:0] y_o,
   output logic [7:0] sp_o,
   output logic [15:0] pc_o,
   output logic [7:0] status_o,
   output logic [7:0] mode_o
);
   crs_state_t state_reg, state_next;
   logic take;
   logic [15:0] product;
   logic [15:0] dividend;
   crs_stack_if sif ();

   // ========================================================================
   // Elaboration check
   if (PC_W != 16) begin : g_bad_pc
      $error("program counter must be 16 bits");
   end

   // ========================================================================
   // Stack address former
   assign sif.sp = sp_o;
   assign sif.page_sel = mode_o[`CRS_MODE_PAGE_BIT]; // see RULE11
   crs_stack_addr u_stack (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .sif(sif)
   );

   assign take = op_valid_i && (state_reg == st_run);
   assign product = {8'h00, acc_o} * {8'h00, operand_i[7:0]};
   assign dividend = {y_o, acc_o};

   // ========================================================================
   // Sequencing: pops take a read cycle, stop and wait hold until woken.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         st_run: begin
            if (take) begin
               if (op_i == pop_accumulator_instr) begin
                  state_next = st_pop_acc;
               end else if (op_i == pop_status_instr) begin
                  state_next = st_pop_status;
               end else if (op_i == stop_oscillation_instr) begin // see RULE10
                  state_next = st_stopped;
               end else if (op_i == wait_interrupt_instr) begin // see RULE10
                  state_next = st_waiting;
               end
            end
         end
         st_pop_acc, st_pop_status: begin
            state_next = st_run;
         end
         st_stopped, st_waiting: begin
            if (wake_i) begin
               state_next = st_run;
            end
         end
      endcase
   end

   // State and busy flag; busy is registered so it reaches the pin from a flop.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg <= st_run;
         busy_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_o <= (state_next != st_run);
      end
   end

   // ========================================================================
   // Accumulator and index registers with multiply and divide.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         acc_o <= 8'h00;
         x_o <= 8'h00;
         y_o <= 8'h00;
      end else if (state_reg == st_pop_acc) begin
         acc_o <= data_i; // see RULE8
      end else if (take) begin
         unique case (op_i)
            op_load_acc: acc_o <= operand_i[7:0]; // see RULE6
            op_load_x: x_o <= operand_i[7:0];
            op_load_y: y_o <= operand_i[7:0];
            op_multiply: begin // see RULE10
               acc_o <= product[7:0];
               y_o <= product[15:8];
            end
            op_divide: begin // see RULE10
               // A zero divisor leaves both registers untouched.
               if (operand_i[7:0] != 8'h00) begin
                  acc_o <= 8'(dividend / {8'h00, operand_i[7:0]});
                  y_o <= 8'(dividend % {8'h00, operand_i[7:0]});
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // Status register; the break bit always reads zero in the register.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         status_o <= `CRS_PS_RESET;
      end else if (state_reg == st_pop_status) begin
         status_o <= data_i & ~(8'h01 << `CRS_PS_BREAK); // see RULE12
      end else if (take) begin
         if (op_i == op_load_status) begin
            status_o <= operand_i[7:0] & ~(8'h01 << `CRS_PS_BREAK); // see RULE12
         end else if (op_i == op_load_acc || op_i == op_load_x || op_i == op_load_y) begin
            status_o[`CRS_PS_ZERO] <= (operand_i[7:0] == 8'h00); // see RULE12
            status_o[`CRS_PS_NEGATIVE] <= operand_i[7];
         end
      end
   end

   // ========================================================================
   // Processor mode register holds page select and clock select.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_o <= `CRS_MODE_RESET;
      end else if (take && op_i == op_load_mode) begin
         mode_o <= operand_i[7:0]; // see RULE11
      end
   end

   // ========================================================================
   // Stack pointer: post-decrement on push, pre-increment on pop.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sp_o <= `CRS_SP_RESET;
      end else if (take) begin
         unique case (op_i)
            op_load_sp: sp_o <= operand_i[7:0]; // see RULE7
            push_accumulator_instr, push_status_instr: sp_o <= sp_o - 8'h01; // see RULE13
            pop_accumulator_instr, pop_status_instr: sp_o <= sp_o + 8'h01; // see RULE13
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // Program counter with whole-word and per-byte loads.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pc_o <= `CRS_PC_RESET;
      end else if (take) begin
         unique case (op_i)
            op_jump: pc_o <= operand_i; // see RULE5
            op_step_pc: pc_o <= pc_o + 16'h0001;
            op_load_pc_low: pc_o[7:0] <= operand_i[7:0]; // see RULE5
            op_load_pc_high: pc_o[15:8] <= operand_i[7:0]; // see RULE5
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // Memory port: one-cycle strobes for stack writes and pop reads.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mem_addr_o <= 16'h0000;
         mem_wdata_o <= 8'h00;
         mem_we_o <= 1'b0;
         mem_re_o <= 1'b0;
      end else begin
         mem_we_o <= 1'b0;
         mem_re_o <= 1'b0;
         if (take) begin
            unique case (op_i)
               push_accumulator_instr: begin // see RULE8
                  mem_addr_o <= sif.push_addr; // see RULE1
                  mem_wdata_o <= acc_o;
                  mem_we_o <= 1'b1;
               end
               push_status_instr: begin // see RULE8
                  mem_addr_o <= sif.push_addr;
                  mem_wdata_o <= status_o;
                  mem_we_o <= 1'b1;
               end
               pop_accumulator_instr, pop_status_instr: begin
                  mem_addr_o <= sif.pop_addr; // see RULE13
                  mem_re_o <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ========================================================================
   // Effective address and illegal-operation flag.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ea_o <= 16'h0000;
         ea_valid_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         ea_valid_o <= take && (op_i == op_ea_x || op_i == op_ea_y);
         illegal_o <= take && (op_i == fast_set_instr || op_i == shift_left_word_instr); // see RULE9
         if (take && op_i == op_ea_x) begin
            ea_o <= operand_i + {8'h00, x_o}; // see RULE3
         end else if (take && op_i == op_ea_y) begin
            ea_o <= operand_i + {8'h00, y_o}; // see RULE4
         end
      end
   end

   // ========================================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   push_write_a: assert property (take && op_i == push_accumulator_instr |=> // see RULE13
      mem_we_o && mem_addr_o == {$past(sif.push_addr)} && sp_o == $past(sp_o) - 8'h01)
      else $error("push did not write then decrement");
   pop_read_a: assert property (take && op_i == pop_status_instr |=> // see RULE13
      mem_re_o && sp_o == $past(sp_o) + 8'h01 && mem_addr_o[7:0] == sp_o)
      else $error("pop did not increment then read");
   pop_load_a: assert property (take && op_i == pop_accumulator_instr |=> // see RULE8
      busy_o ##1 (acc_o == $past(data_i) && !busy_o))
      else $error("popped byte not in accumulator");
   stack_page_a: assert property (mem_we_o |-> // see RULE11
      mem_addr_o[15:8] == {7'h00, $past(mode_o[`CRS_MODE_PAGE_BIT])})
      else $error("stack page does not follow mode bit");
   ea_x_add_a: assert property (take && op_i == op_ea_x |=> // see RULE3
      ea_valid_o && ea_o == $past(operand_i) + {8'h00, $past(x_o)})
      else $error("x indexed address wrong");
   ea_y_add_a: assert property (take && op_i == op_ea_y |=> // see RULE4
      ea_valid_o && ea_o == $past(operand_i) + {8'h00, $past(y_o)})
      else $error("y indexed address wrong");
   illegal_op_a: assert property (take && (op_i == fast_set_instr || // see RULE9
      op_i == shift_left_word_instr) |=> illegal_o && !mem_we_o && !mem_re_o &&
      $stable(acc_o) && $stable(sp_o) && $stable(status_o))
      else $error("unsupported operation not refused");
   break_zero_a: assert property (!status_o[`CRS_PS_BREAK]) // see RULE12
      else $error("break bit set in status register");
   stop_hold_a: assert property (take && (op_i == stop_oscillation_instr || // see RULE10
      op_i == wait_interrupt_instr) ##1 !wake_i |=> busy_o)
      else $error("stop released without wake");
   pc_low_a: assert property (take && op_i == op_load_pc_low |=> // see RULE5
      pc_o[15:8] == $past(pc_o[15:8]) && pc_o[7:0] == $past(operand_i[7:0]))
      else $error("low byte load disturbed high byte");
endmodule

// File: crs_defs.svh
// Purpose: Constants of the core register set: reset values, bit positions, page bytes.
// Assumes: Included by bare name from the design modules and the testbench.
// Notes: Definitions only.
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ==========================================================================
// Stack page bytes
`define CRS_PAGE0_HI 8'h00
`define CRS_PAGE1_HI 8'h01

// ==========================================================================
// Processor status bit positions, bit 0 upward
`define CRS_PS_CARRY 0
`define CRS_PS_ZERO 1
`define CRS_PS_IRQ_DIS 2
`define CRS_PS_DECIMAL 3
`define CRS_PS_BREAK 4
`define CRS_PS_INDEX_MEM 5
`define CRS_PS_OVERFLOW 6
`define CRS_PS_NEGATIVE 7

// ==========================================================================
// Processor mode register: address and bit positions
`define CRS_MODE_ADDR 16'h003b
`define CRS_MODE_PAGE_BIT 2
`define CRS_MODE_CLK_SEL_BIT 7

// ==========================================================================
// Reset values
`define CRS_SP_RESET 8'hff
`define CRS_PC_RESET 16'h0000
`define CRS_PS_RESET 8'h04
`define CRS_MODE_RESET 8'h00

`endif

// File: crs_pkg.sv
// Purpose: Types shared by the core register set modules.
// Assumes: Nothing beyond the constants header.
// Notes: Operation codes come from the instruction sequencer.
package crs_pkg;
   // ========================================================================
   // Operations the sequencer may request
   typedef enum logic [4:0] {
      op_nop, op_load_acc, op_load_x, op_load_y, op_load_sp, op_load_status,
      op_load_mode, op_jump, op_step_pc, op_load_pc_low, op_load_pc_high,
      push_accumulator_instr, push_status_instr, pop_accumulator_instr,
      pop_status_instr, op_ea_x, op_ea_y, op_multiply, op_divide,
      stop_oscillation_instr, wait_interrupt_instr, fast_set_instr,
      shift_left_word_instr
   } crs_op_t;

   // ========================================================================
   // Sequencing states
   typedef enum logic [2:0] {
      st_run, st_pop_acc, st_pop_status, st_stopped, st_waiting
   } crs_state_t;
endpackage

// File: crs_stack_if.sv
// Purpose: Carries stack pointer and page select to the stack address former.
// Assumes: One clock domain.
// Notes: Addresses come back combinationally.
`timescale 1ns/10ps
interface crs_stack_if;
   logic page_sel;
   logic [7:0] sp;
   logic [15:0] push_addr;
   logic [15:0] pop_addr;
   modport core (output page_sel, output sp, input push_addr, input pop_addr);
   modport calc (input page_sel, input sp, output push_addr, output pop_addr);
endinterface

// File: crs_stack_addr.sv
// Purpose: Forms 16-bit stack addresses from the page select and stack pointer.
// Assumes: Stack pointer wraps within its page.
// Notes: Pop address is the pre-incremented pointer.
`timescale 1ns/10ps
`include "crs_defs.svh"
module crs_stack_addr (
   input wire logic clk_i,
   input wire logic rst_i,
   crs_stack_if.calc sif
);
   logic [7:0] page_hi;
   logic [7:0] sp_inc;

   // ========================================================================
   // Address forming
   // The page byte is a mux, not an adder, so the page never carries over.
   assign page_hi = sif.page_sel ? `CRS_PAGE1_HI : `CRS_PAGE0_HI; // see RULE2
   assign sp_inc = sif.sp + 8'h01;
   assign sif.push_addr = {page_hi, sif.sp}; // see RULE1
   assign sif.pop_addr = {page_hi, sp_inc}; // see RULE13

   // Upper byte is only ever page zero or page one, and the low byte wraps inside the page.
   page_byte_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
      sif.push_addr == {7'h00, sif.page_sel, sif.sp} &&
      sif.pop_addr == {7'h00, sif.page_sel, 8'(sif.sp + 8'h01)})
      else $error("stack page byte wrong");
endmodule

// File: test_cpu_core_register_set.sv
// Purpose: Self-checking bench for the core register set, driven at its own ports.
// Assumes: Operations are requested one at a time with an idle cycle between them.
// Notes: Inputs change on the falling edge, so the rising edge always sees settled values.
`timescale 1ns/10ps
`include "crs_defs.svh"
module test_cpu_core_register_set
   import crs_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   crs_op_t op = op_nop;
   logic [15:0] operand = 16'h0000;
   logic [7:0] data = 8'h00;
   logic wake = 1'b0;
   logic busy, mem_we, mem_re, ea_valid, illegal;
   logic [15:0] mem_addr, ea, pc;
   logic [7:0] mem_wdata, acc, x, y, sp, status, mode;
   int errors = 0;
   int check_count = 0;

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

   // ========================================================================
   // Clock and device
   always #20 ref_clk = ~ref_clk;

   crs_regset i_dut (.ref_clk_i(ref_clk), .rst_i(rst), .op_valid_i(op_valid), .op_i(op),
      .operand_i(operand), .data_i(data), .wake_i(wake), .busy_o(busy),
      .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
      .ea_o(ea), .ea_valid_o(ea_valid), .illegal_o(illegal), .acc_o(acc), .x_o(x), .y_o(y),
      .sp_o(sp), .pc_o(pc), .status_o(status), .mode_o(mode));

   // ========================================================================
   // Shared tasks
   // One request held for exactly one rising edge; returns where its one-cycle outputs stand.
   task automatic do_op(input crs_op_t code, input logic [15:0] opnd);
      @(negedge ref_clk);
      op_valid = 1'b1;
      op = code;
      operand = opnd;
      @(negedge ref_clk);
      op_valid = 1'b0;
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic results();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ========================================================================
   // Scenarios
   // Values seen while reset is still held.
   task automatic t_reset();
      `CHK({acc, x, y}, 24'h000000)
      `CHK(sp, `CRS_SP_RESET)
      `CHK(pc, `CRS_PC_RESET)
      `CHK(status, `CRS_PS_RESET)
      `CHK(mode, `CRS_MODE_RESET)
      `CHK({busy, mem_we, mem_re, ea_valid, illegal}, 5'h00)
   endtask

   // Index sums must carry into the high byte; the operand is a full 16-bit value.
   task automatic t_index();
      do_op(op_load_x, 16'h0010);
      do_op(op_load_y, 16'h0080);
      do_op(op_ea_x, 16'h12f8);
      `CHK(ea_valid, 1'b1)
      `CHK(ea, 16'h1308)
      do_op(op_ea_y, 16'h00f0);
      `CHK(ea, 16'h0170)
      do_op(op_load_acc, 16'h0080);
      `CHK(acc, 8'h80)
      `CHK(status[`CRS_PS_NEGATIVE], 1'b1)
      do_op(op_load_acc, 16'h0000);
      `CHK(status[`CRS_PS_ZERO], 1'b1)
   endtask

   // Pushes on both stack pages and pops on page one, checking address, pointer and data order.
   task automatic t_stack();
      do_op(op_load_acc, 16'h005a);
      do_op(push_accumulator_instr, 16'h0000);
      `CHK({mem_we, mem_addr, mem_wdata}, {1'b1, 16'h00ff, 8'h5a})
      `CHK(sp, 8'hfe)
      do_op(op_load_mode, 16'h0004);
      `CHK(mode, 8'h04)
      do_op(op_load_status, 16'h00db);
      `CHK(status, 8'hcb)
      do_op(push_status_instr, 16'h0000);
      `CHK({mem_we, mem_addr, mem_wdata}, {1'b1, 16'h01fe, 8'hcb})
      `CHK(sp, 8'hfd)
      data = 8'hc3;
      do_op(pop_accumulator_instr, 16'h0000);
      `CHK({mem_re, busy, mem_addr}, {2'b11, 16'h01fe})
      `CHK(sp, 8'hfe)
      @(negedge ref_clk);
      `CHK({acc, busy, mem_re}, {8'hc3, 2'b00})
      data = 8'hff;
      do_op(pop_status_instr, 16'h0000);
      `CHK({mem_re, mem_addr}, {1'b1, 16'h01ff})
      @(negedge ref_clk);
      `CHK(status, 8'hef)
      do_op(op_load_mode, 16'h0080);
      do_op(push_accumulator_instr, 16'h0000);
      `CHK({mode, mem_addr}, {8'h80, 16'h00ff})
      do_op(op_load_sp, 16'h0000);
      `CHK(sp, 8'h00)
      do_op(push_accumulator_instr, 16'h0000);
      `CHK({mem_addr, sp}, {16'h0000, 8'hff})
   endtask

   // Byte loads touch one half only; a step must carry from the low half into the high.
   task automatic t_pc();
      do_op(op_load_pc_low, 16'h0034);
      do_op(op_load_pc_high, 16'h0012);
      `CHK(pc, 16'h1234)
      do_op(op_load_pc_low, 16'h00cd);
      `CHK(pc, 16'h12cd)
      do_op(op_jump, 16'habff);
      `CHK(pc, 16'habff)
      do_op(op_step_pc, 16'h0000);
      `CHK(pc, 16'hac00)
   endtask

   // Refused operations must pulse the flag for one cycle, write no memory and leave the accumulator alone.
   task automatic t_illegal();
      crs_op_t bad[2];
      bad[0] = fast_set_instr;
      bad[1] = shift_left_word_instr;
      do_op(op_load_acc, 16'h0033);
      foreach (bad[i]) begin
         do_op(bad[i], 16'h0055);
         `CHK({illegal, acc, mem_we}, {1'b1, 8'h33, 1'b0})
         @(negedge ref_clk);
         `CHK(illegal, 1'b0)
      end
   endtask

   // Multiply fills y and acc; divide leaves quotient and remainder, and ignores a zero divisor.
   task automatic t_muldiv();
      do_op(op_load_acc, 16'h0012);
      do_op(op_multiply, 16'h0010);
      `CHK({y, acc}, 16'h0120)
      do_op(op_divide, 16'h0007);
      `CHK({y, acc}, 16'h0129)
      do_op(op_divide, 16'h0000);
      `CHK({y, acc}, 16'h0129)
   endtask

   // Stop and wait hold off requests until wake; the wait for release is bounded.
   task automatic t_halt();
      crs_op_t hold[2];
      int n;
      hold[0] = stop_oscillation_instr;
      hold[1] = wait_interrupt_instr;
      foreach (hold[i]) begin
         do_op(op_load_acc, 16'h0011);
         do_op(hold[i], 16'h0000);
         `CHK(busy, 1'b1)
         do_op(op_load_acc, 16'h0099);
         `CHK({busy, acc}, {1'b1, 8'h11})
         @(negedge ref_clk);
         wake = 1'b1;
         @(negedge ref_clk);
         wake = 1'b0;
         n = 0;
         while (busy !== 1'b0 && n < 4) begin
            @(negedge ref_clk);
            n++;
         end
         `CHK(busy, 1'b0)
      end
   endtask

   // A reset in mid-run must restore x, sp, pc and mode, and the next request must be taken.
   task automatic t_midreset();
      do_op(op_load_x, 16'h0042);
      do_op(push_status_instr, 16'h0000);
      @(negedge ref_clk);
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      `CHK({x, sp, pc, mode}, {8'h00, `CRS_SP_RESET, `CRS_PC_RESET, `CRS_MODE_RESET})
      do_op(op_load_x, 16'h0042);
      `CHK(x, 8'h42)
   endtask

   // ========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (5) @(negedge ref_clk);
      t_reset();
      rst = 1'b0;
      t_index();
      t_stack();
      t_pc();
      t_illegal();
      t_muldiv();
      t_halt();
      t_midreset();
      results();
   end

   // The whole sequence needs well under 200 cycles; 2000 leaves ample margin.
   initial begin
      #(40 * 2000);
      errors++;
      results();
   end
endmodule
